/* design/cscp_defines.vh */
// Constants for the clock chip serial control port
`ifndef CSCP_DEFINES_VH
`define CSCP_DEFINES_VH
`define CSCP_INSTR_BITS      5'h10
`define CSCP_BYTE_BITS       3'h7
`define CSCP_ADDR_W          10
`define CSCP_ADDR_LAST       10'h232
`define CSCP_ADDR_ZERO       10'h000
`define CSCP_ADDR_PORTCFG    10'h000
`define CSCP_ADDR_READSRC    10'h004
`define CSCP_PORTCFG_RESET   8'h18
`define CSCP_BIT_SDO_ACT     0
`define CSCP_BIT_LSB_FIRST   1
`define CSCP_BIT_LSB_MIRROR  6
`define CSCP_BIT_SDO_MIRROR  7
`define CSCP_BIT_LONG_LO     3
`define CSCP_BIT_LONG_HI     4
`define CSCP_BIT_UPDATE      0
`define CSCP_BIT_READSRC     0
`define CSCP_LEN_STREAM      2'h3
`define CSCP_IDX_RW          15
`define CSCP_IDX_LEN_HI      14
`define CSCP_IDX_LEN_LO      13
`define CSCP_IDX_ADDR_HI     9
`endif

/* design/cscp_sync.v */
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
module cscp_sync (
    input  wire mclk_in,
    input  wire rst_n_in,
    input  wire rst_val_in,
    input  wire d_in,
    output wire q_out
);
    reg meta_r;
    reg q_r;
    // Reset value is always zero; rst_val_in is not used
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_r    <= meta_r;
        end
    end
    assign q_out = q_r;
endmodule

/* design/cscp_port.v */
// Serial control port with staging and active register banks
`timescale 1ns/1ps
`include "cscp_defines.vh"
// Overview of operation
// - Shared pin default; bit0 moves readback to separate output
// - Readback on dedicated pin or shared pin
// - Sample on rising, launch on falling
// - Both data pins released while select high
// - Sixteen-bit instruction on first rising edges
// - Length field picks 1,2,3 bytes, stream
// - Short transfers stall at byte boundaries
// - Select high after last byte ends write
// - Mid-byte select rise aborts and discards
// - Stream moves any bytes, address steps
// - Every address stepped, blanks ignored
// - Writes land in staging buffer
// - Update bit copies staging to active
// - Read shifts N bytes or streams
// - Read source picks staging or active
// - Addresses zero to update register decoded
// - Direction, length, thirteen-bit address; only address bits 9 to 0 are decoded
// - Length codes map; top address bits zero
// - MSB first decrements, LSB first increments
// - Stream stops at update register address
module cscp_port (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire        sclk_in,
    input  wire        cs_n_in,
    input  wire        sdio_in,
    output reg         sdio_out,
    output reg         sdio_oe_out,
    output reg         dedicated_read_out_pin_out,
    output reg         dedicated_read_out_pin_oe_out,
    output reg         lsb_first_out,
    output reg         update_pulse_out,
    output reg  [7:0]  act_rd_data_out,
    input  wire [9:0]  act_rd_addr_in
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_INSTR = 2'h1;
    localparam ST_DATA  = 2'h2;
    localparam ST_STALL = 2'h3;
    localparam NREG     = 11'h233;

    wire sclk_s;
    wire cs_n_s;
    wire sdio_s;
    cscp_sync u_sync_clk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rst_val_in(1'b0),
                          .d_in(sclk_in), .q_out(sclk_s));
    cscp_sync u_sync_cs  (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rst_val_in(1'b1),
                          .d_in(~cs_n_in), .q_out(cs_n_s));
    cscp_sync u_sync_dat (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rst_val_in(1'b0),
                          .d_in(sdio_in), .q_out(sdio_s));
    // Select is carried inverted through the synchroniser so reset means deselected
    wire cs_act = cs_n_s;

    reg        sclk_d_r;
    reg        cs_d_r;
    reg [1:0]  state_r;
    reg [4:0]  bcnt_r;
    reg [15:0] instr_r;
    reg [7:0]  shift_r;
    reg [9:0]  addr_r;
    reg [1:0]  bytes_r;
    reg        done_r;
    reg [7:0]  rd_byte_r;
    reg [3:0]  rst_cnt_r;
    reg        cs_was_stall_r;
    reg [7:0]  stage_r [0:NREG-1];
    reg [7:0]  act_r   [0:NREG-1];

    wire rise = sclk_s & ~sclk_d_r;
    wire fall = ~sclk_s & sclk_d_r;
    wire cs_fall = cs_act & ~cs_d_r;
    wire cs_rise = ~cs_act & cs_d_r;

    wire lsb_first = stage_r[`CSCP_ADDR_PORTCFG][`CSCP_BIT_LSB_FIRST] |
                     stage_r[`CSCP_ADDR_PORTCFG][`CSCP_BIT_LSB_MIRROR];
    wire sdo_act   = stage_r[`CSCP_ADDR_PORTCFG][`CSCP_BIT_SDO_ACT] |
                     stage_r[`CSCP_ADDR_PORTCFG][`CSCP_BIT_SDO_MIRROR];
    wire rd_src    = act_r[`CSCP_ADDR_READSRC][`CSCP_BIT_READSRC];

    // Bit reversal when LSB first is active
    function [7:0] cscp_rev8;
        input [7:0] v;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1)
                cscp_rev8[k] = v[7-k];
        end
    endfunction

    function [15:0] cscp_rev16;
        input [15:0] v;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1)
                cscp_rev16[k] = v[15-k];
        end
    endfunction

    function cscp_in_map;
        input [9:0] a;
        begin
            cscp_in_map = (a <= `CSCP_ADDR_LAST);
        end
    endfunction

    wire [15:0] instr_nxt = {instr_r[14:0], sdio_s};
    wire [15:0] instr_ord = lsb_first ? cscp_rev16(instr_nxt) : instr_nxt;
    wire [7:0]  byte_nxt  = {shift_r[6:0], sdio_s};
    wire [7:0]  byte_ord  = lsb_first ? cscp_rev8(byte_nxt) : byte_nxt;
    wire        is_read   = instr_r[`CSCP_IDX_RW];
    wire [1:0]  len_code  = instr_r[`CSCP_IDX_LEN_HI:`CSCP_IDX_LEN_LO];
    wire        streaming = (len_code == `CSCP_LEN_STREAM);
    wire [9:0]  addr_step = lsb_first ? addr_r + 10'h001 : addr_r - 10'h001;
    wire        at_bound  = (bcnt_r[2:0] == 3'h0);
    wire        last_byte = ~streaming & (bytes_r == len_code);

    function [7:0] cscp_rd;
        input [9:0] a;
        input       src;
        begin
            if (!cscp_in_map(a))
                cscp_rd = 8'h00;
            else if (src)
                cscp_rd = act_r[a];
            else
                cscp_rd = stage_r[a];
        end
    endfunction

    wire [7:0] rd_word = cscp_rd(addr_r, rd_src);
    wire [7:0] rd_ord  = lsb_first ? cscp_rev8(rd_word) : rd_word;

    // Serial state machine
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_d_r       <= 1'b0;
            cs_d_r         <= 1'b0;
            state_r        <= ST_IDLE;
            bcnt_r         <= 5'h00;
            instr_r        <= 16'h0000;
            shift_r        <= 8'h00;
            addr_r         <= 10'h000;
            bytes_r        <= 2'h0;
            done_r         <= 1'b0;
            rd_byte_r      <= 8'h00;
            rst_cnt_r      <= 4'h0;
            cs_was_stall_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r   <= cs_act;
            if (cs_rise) begin
                if (state_r == ST_DATA && at_bound && !streaming && !done_r) begin
                    state_r <= ST_STALL;
                end else if (state_r == ST_INSTR && at_bound && bcnt_r != 5'h00) begin
                    state_r <= ST_STALL;
                end else begin
                    state_r <= ST_IDLE;
                    bcnt_r  <= 5'h00;
                    done_r  <= 1'b0;
                end
            end else if (cs_fall) begin
                rst_cnt_r <= 4'h0;
                if (state_r == ST_STALL) begin
                    cs_was_stall_r <= 1'b1;
                    // Only an instruction-phase stall leaves a nonzero bit count behind
                    state_r <= (bcnt_r != 5'h00) ? ST_INSTR : ST_DATA;
                end else begin
                    state_r <= ST_INSTR;
                    bcnt_r  <= 5'h00;
                    bytes_r <= 2'h0;
                    done_r  <= 1'b0;
                end
            end else if (cs_act && rise) begin
                rst_cnt_r <= (rst_cnt_r == 4'hf) ? rst_cnt_r : rst_cnt_r + 4'h1;
                if (state_r == ST_INSTR) begin
                    instr_r <= instr_nxt;
                    if (bcnt_r == `CSCP_INSTR_BITS - 5'h01) begin
                        state_r <= ST_DATA;
                        bcnt_r  <= 5'h00;
                        addr_r  <= instr_ord[`CSCP_IDX_ADDR_HI:0];
                        instr_r <= instr_ord;
                    end else begin
                        bcnt_r <= bcnt_r + 5'h01;
                    end
                end else if (state_r == ST_DATA && !done_r) begin
                    shift_r <= byte_nxt;
                    if (bcnt_r[2:0] == `CSCP_BYTE_BITS) begin
                        bcnt_r <= 5'h00;
                        if (!streaming)
                            bytes_r <= bytes_r + 2'h1;
                        if (addr_r == `CSCP_ADDR_LAST || last_byte)
                            done_r <= 1'b1;
                        else
                            addr_r <= addr_step;
                    end else begin
                        bcnt_r <= bcnt_r + 5'h01;
                    end
                end
            end else if (cs_act && fall && state_r == ST_DATA && is_read) begin
                // Load the bits after the first of each byte at its first falling edge; the first bit goes straight to the pin
                if (bcnt_r[2:0] == 3'h0)
                    rd_byte_r <= {rd_ord[6:0], 1'b0};
                else
                    rd_byte_r <= {rd_byte_r[6:0], 1'b0};
            end
            // A select-low period with one to seven clock rises clears a stalled transfer
            if (cs_rise && cs_was_stall_r && rst_cnt_r != 4'h0 && rst_cnt_r < 4'h8 &&
                state_r != ST_DATA) begin
                state_r        <= ST_IDLE;
                bcnt_r         <= 5'h00;
                cs_was_stall_r <= 1'b0;
            end
            if (cs_rise && state_r == ST_DATA && bcnt_r == 5'h00)
                cs_was_stall_r <= 1'b0;
        end
    end

    // Pin drivers, launched on the falling edge
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sdio_out                      <= 1'b0;
            sdio_oe_out                   <= 1'b0;
            dedicated_read_out_pin_out    <= 1'b0;
            dedicated_read_out_pin_oe_out <= 1'b0;
            lsb_first_out                 <= 1'b0;
        end else begin
            lsb_first_out <= lsb_first;
            if (!cs_act) begin
                sdio_oe_out                   <= 1'b0;
                dedicated_read_out_pin_oe_out <= 1'b0;
            end else if (fall && state_r == ST_DATA && is_read && !done_r) begin
                sdio_oe_out                   <= ~sdo_act;
                dedicated_read_out_pin_oe_out <= sdo_act;
                sdio_out                      <= at_bound ? rd_ord[7] : rd_byte_r[7];
                dedicated_read_out_pin_out    <= at_bound ? rd_ord[7] : rd_byte_r[7];
            end else if (state_r != ST_DATA || !is_read || done_r) begin
                sdio_oe_out                   <= 1'b0;
                dedicated_read_out_pin_oe_out <= sdo_act & is_read & (state_r == ST_DATA);
            end
        end
    end

    wire wr_strobe = cs_act && rise && state_r == ST_DATA && !done_r && !is_read &&
                     bcnt_r[2:0] == `CSCP_BYTE_BITS;
    wire do_update = act_r[`CSCP_ADDR_LAST][`CSCP_BIT_UPDATE] |
                     stage_r[`CSCP_ADDR_LAST][`CSCP_BIT_UPDATE];

    // Staging and active banks
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_reg
            always @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage_r[g] <= (g == 0) ? `CSCP_PORTCFG_RESET : 8'h00;
                    act_r[g]   <= (g == 0) ? `CSCP_PORTCFG_RESET : 8'h00;
                end else begin
                    if (wr_strobe && addr_r == g) begin
                        stage_r[g] <= (g == 0) ? (byte_ord | `CSCP_PORTCFG_RESET) : byte_ord;
                    end else if (g == `CSCP_ADDR_LAST && stage_r[g][`CSCP_BIT_UPDATE]) begin
                        stage_r[g] <= 8'h00;
                    end
                    if (stage_r[`CSCP_ADDR_LAST][`CSCP_BIT_UPDATE] && g != `CSCP_ADDR_LAST)
                        act_r[g] <= stage_r[g];
                end
            end
        end
    endgenerate

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            update_pulse_out <= 1'b0;
            act_rd_data_out  <= 8'h00;
        end else begin
            update_pulse_out <= do_update;
            act_rd_data_out  <= cscp_in_map(act_rd_addr_in) ? act_r[act_rd_addr_in] : 8'h00;
        end
    end
endmodule

/* tb/cscp_port_sva.sv */
// Checker for the serial control port pin behaviour
`timescale 1ns/1ps
module cscp_port_sva (
    input wire mclk_in,
    input wire rst_n_in,
    input wire sclk_in,
    input wire cs_n_in,
    input wire sdio_out,
    input wire sdio_oe_out,
    input wire dedicated_read_out_pin_out,
    input wire dedicated_read_out_pin_oe_out,
    input wire update_pulse_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wire dedicated_read_out_pin    = dedicated_read_out_pin_out;
    wire sdo_oe = dedicated_read_out_pin_oe_out;
    sequence s_idle;
        cs_n_in[*6];
    endsequence
    sequence s_sdio_launch;
        sdio_oe_out && $past(sdio_oe_out) && $changed(sdio_out);
    endsequence
    sequence s_sdo_launch;
        sdo_oe && $past(sdo_oe) && $changed(dedicated_read_out_pin);
    endsequence
    a_idle_release: assert property (s_idle |-> !sdio_oe_out && !sdo_oe) else $error("pin driven while idle");
    a_one_driver: assert property (!(sdio_oe_out && sdo_oe)) else $error("both read pins driven");
    a_drive_start: assert property ($rose(sdio_oe_out || sdo_oe) |-> !cs_n_in && !sclk_in)
        else $error("drive began outside read data");
    a_sdio_launch: assert property (s_sdio_launch |-> !sclk_in) else $error("shared pin changed on high clock");
    a_sdo_launch: assert property (s_sdo_launch |-> !sclk_in) else $error("read pin changed on high clock");
    a_hold_high: assert property (sdio_oe_out && sclk_in && $past(sclk_in) |-> $stable(sdio_out))
        else $error("shared pin moved while clock high");
    a_upd_single: assert property (update_pulse_out |=> !update_pulse_out) else $error("update pulse too long");
    a_upd_framed: assert property (update_pulse_out |-> !$past(cs_n_in, 2)) else $error("update outside frame");
endmodule
bind cscp_port cscp_port_sva u_sva (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
    .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out), .dedicated_read_out_pin_out(dedicated_read_out_pin_out),
    .dedicated_read_out_pin_oe_out(dedicated_read_out_pin_oe_out), .update_pulse_out(update_pulse_out)
);

/* tb/cscp_host.sv */
// Serial master model driving the control port
`timescale 1ns/1ps
module cscp_host (
    input  wire mclk_in,
    input  wire sdio_in,
    input  wire sdo_in,
    output reg  sclk_out,
    output reg  cs_n_out,
    output reg  sd_out,
    output reg  sd_oe_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sd_out = 1'b0;
        sd_oe_out = 1'b0;
    end
    // One 80 ns clock period; read bit is taken just before the rise
    task automatic shift(input logic b, input logic s, output logic r);
        sd_out = b;
        repeat (5) @(posedge mclk_in);
        #1 r = s ? sdo_in : sdio_in;
        sclk_out = 1'b1;
        repeat (5) @(posedge mclk_in);
        #1 sclk_out = 1'b0;
    endtask
    task automatic frame(input logic lo);
        @(posedge mclk_in);
        #1 cs_n_out = ~lo;
        sd_oe_out = 1'b0;
        repeat (10) @(posedge mclk_in);
        #1;
    endtask
    task automatic put(input logic [15:0] v, input int n);
        logic r;
        sd_oe_out = 1'b1;
        for (int i = n - 1; i >= 0; i--) shift(v[i], 1'b0, r);
    endtask
    task automatic get(input logic s, output logic [7:0] v);
        sd_oe_out = 1'b0;
        for (int i = 7; i >= 0; i--) shift(1'b0, s, v[i]);
    endtask
endmodule

/* tb/cscp_port_tb_top.sv */
// Testbench for the serial control port
`timescale 1ns/1ps
module cscp_port_tb_top;
    logic       mclk_in = 1'b0;
    logic       rst_n_in;
    logic [9:0] rd_addr;
    logic       flt;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         upd_cnt = 0;
    wire        sclk, cs_n, sd, sd_oe, sdio_out, sdio_oe, dedicated_read_out_pin, sdo_oe, lsb, upd;
    wire [7:0]  act;
    wire        sdio_w = sdio_oe ? sdio_out : (sd_oe ? sd : flt);
    wire        sdo_w = sdo_oe ? dedicated_read_out_pin : flt;
    always #4 mclk_in = ~mclk_in;
    always @(posedge mclk_in) flt <= ~flt;
    always @(posedge mclk_in) if (upd === 1'b1) upd_cnt++;
    cscp_port uut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n), .sdio_in(sdio_w),
        .sdio_out(sdio_out), .sdio_oe_out(sdio_oe), .dedicated_read_out_pin_out(dedicated_read_out_pin),
        .dedicated_read_out_pin_oe_out(sdo_oe), .lsb_first_out(lsb), .update_pulse_out(upd),
        .act_rd_data_out(act), .act_rd_addr_in(rd_addr)
    );
    cscp_host host (
        .mclk_in(mclk_in), .sdio_in(sdio_w), .sdo_in(sdo_w), .sclk_out(sclk), .cs_n_out(cs_n),
        .sd_out(sd), .sd_oe_out(sd_oe)
    );
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask
    task automatic act_rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        #1 rd_addr = a;
        repeat (2) @(posedge mclk_in);
        #1 chk(exp, act);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host.frame(1'b1);
        host.put({6'h00, a}, 16);
        host.put({8'h00, d}, 8);
        host.frame(1'b0);
    endtask
    task automatic update;
        int c0;
        c0 = upd_cnt;
        wr(10'h232, 8'h01);
        chk(8'h01, 8'(upd_cnt - c0));
    endtask
    task automatic rd(input logic [15:0] ins, input logic [7:0] exp);
        logic [7:0] v;
        host.frame(1'b1);
        host.put(ins, 16);
        host.get(1'b0, v);
        host.frame(1'b0);
        chk(exp, v);
    endtask
    task automatic t_stage;
        act_rd(10'h000, 8'h18);
        chk(8'h00, {5'h00, sdio_oe, sdo_oe, lsb});
        wr(10'h010, 8'ha5);
        act_rd(10'h010, 8'h00);
        update();
        act_rd(10'h010, 8'ha5);
        $display("test stage done");
    endtask
    task automatic t_stall;
        host.frame(1'b1);
        host.put(16'h2021, 16);
        host.put(16'h0011, 8);
        host.frame(1'b0);
        host.frame(1'b1);
        host.put(16'h0022, 8);
        host.frame(1'b0);
        update();
        act_rd(10'h021, 8'h11);
        act_rd(10'h020, 8'h22);
        $display("test stall done");
    endtask
    task automatic t_abort;
        host.frame(1'b1);
        host.put(16'h0030, 16);
        host.put(16'h000f, 4);
        host.frame(1'b0);
        host.frame(1'b1);
        host.put(16'h0000, 8);
        host.frame(1'b0);
        host.frame(1'b1);
        host.put(16'h0000, 2);
        host.frame(1'b0);
        wr(10'h031, 8'h5a);
        update();
        act_rd(10'h030, 8'h00);
        act_rd(10'h031, 8'h5a);
        $display("test abort done");
    endtask
    task automatic t_read;
        logic [7:0] v;
        wr(10'h004, 8'h01);
        update();
        wr(10'h010, 8'h3c);
        rd(16'h8010, 8'ha5);
        wr(10'h004, 8'h00);
        update();
        wr(10'h010, 8'h77);
        rd(16'h8010, 8'h77);
        wr(10'h000, 8'h99);
        update();
        host.frame(1'b1);
        host.put(16'ha011, 16);
        host.get(1'b1, v);
        chk(8'h00, v);
        host.get(1'b1, v);
        host.frame(1'b0);
        chk(8'h77, v);
        $display("test read done");
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rst_n_in = 1'b0;
        rd_addr = 10'h000;
        flt = 1'b0;
        repeat (10) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        repeat (6) @(posedge mclk_in);
        t_stage();
        t_stall();
        t_abort();
        t_read();
        wrap_up();
    end
endmodule
